/* design/sso_consts.svh */
// Constants of the shift, subtract and flow execution unit
`ifndef SSO_CONSTS_SVH
`define SSO_CONSTS_SVH

// ----------------------------------------------------------------------
// Data values
// ----------------------------------------------------------------------
`define SSO_RST_WORD     16'h0000
`define SSO_ONES         16'hFFFF
`define SSO_PC_STEP      16'h0002
`define SSO_DEF_DEFAULT_WORKING_REGISTER     4'h0
`define SSO_SHIFT_LIM    5'h10
`define SSO_RPT_LIT_MSB  13
`define SSO_RET_LIT_MSB  9
`define SSO_UPPER_MSB    23
`define SSO_UPPER_LSB    16

// ----------------------------------------------------------------------
// Timing: calls and table reads take 2 cycles, returns 3 (2 when short)
// ----------------------------------------------------------------------
`define SSO_WAIT_NONE    1'b0
`define SSO_WAIT_LONG    1'b1

`endif

/* design/sso_pkg.sv */
// Types of the shift, subtract and flow execution unit
package sso_pkg;

  // --------------------------------------------------------------------
  // Operations
  // --------------------------------------------------------------------
  typedef enum logic [4:0] {
    relative_call_op, computed_call_op, repeat_lit_op, repeat_reg_op,
    soft_reset_op, interrupt_return_op, literal_return_op, plain_return_op,
    rotate_left_carry_op, rotate_left_plain_op, rotate_right_carry_op,
    rotate_right_plain_op, sign_extend_op, set_all_ones_op, left_shift_op,
    left_shift_multi_op, subtract_op, subtract_borrow_op,
    reverse_subtract_op, reverse_subtract_borrow_op, nibble_swap_op,
    byte_swap_op, upper_table_read_op
  } sso_op_e;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic ov; logic n; logic z; logic dc; logic c;
  } sso_flags_s;

  typedef struct packed {
    sso_op_e     op;
    logic        use_file;   // Operand is the file register value
    logic        to_default_working_register;    // File forms: result to default register
    logic        use_lit;    // Second operand is the literal
    logic        ret_short;  // Return takes the short 2-cycle path
    logic [3:0]  wb;
    logic [3:0]  ws;
    logic [3:0]  wd;
    logic [15:0] lit;
    logic [15:0] fval;
    logic [15:0] pc;
  } sso_req_s;

  typedef struct packed {
    logic        done;
    logic        f_wr;
    logic [15:0] f_data;
    logic        pc_load;
    logic [15:0] pc_target;
    logic        push;
    logic [15:0] push_addr;
    logic        sw_reset;
    logic        prog_rd;
    logic [15:0] prog_addr;
  } sso_out_s;

  typedef struct packed {
    logic             busy;
    logic             wait_cnt;
    sso_req_s         held;
    logic [15:0]      rpt;
    sso_flags_s       flags;
    logic [15:0][15:0] default_working_register;
    sso_out_s         out;
  } sso_state_s;

endpackage

/* design/sso_sub.sv */
// Subtractor with borrow input and five arithmetic flags
`timescale 1ns/1ps
`default_nettype none
`include "sso_consts.svh"
module sso_sub
  import sso_pkg::*;
(
  // Operands
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic        cin,
  // Result
  output logic [15:0]      res,
  output sso_flags_s       flg
);
  logic [16:0] full;
  logic [4:0]  low;

  // a + ~b + cin, carry set means no borrow
  assign full    = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
  assign low     = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
  assign res     = full[15:0];
  assign flg.c   = full[16];
  assign flg.dc  = low[4];
  assign flg.n   = full[15];
  assign flg.z   = (full[15:0] == `SSO_RST_WORD);
  // Overflow when signs differ and result sign leaves the minuend's
  assign flg.ov  = (a[15] != b[15]) && (full[15] != a[15]);
endmodule
`default_nettype wire

/* design/sso_shift.sv */
// Rotate and left shift unit
`timescale 1ns/1ps
`default_nettype none
`include "sso_consts.svh"
module sso_shift
  import sso_pkg::*;
(
  // Operand
  input  wire sso_op_e     op,
  input  wire logic [15:0] val,
  input  wire logic        cin,
  input  wire logic [4:0]  cnt,
  // Result
  output logic [15:0]      res,
  output logic             cout,
  output logic             ov
);
  // Carry passes through unless the operation moves a bit into it
  always_comb begin
    res  = val;
    cout = cin;
    ov   = 1'b0;
    case (op)
      rotate_left_carry_op: begin
        res  = {val[14:0], cin};
        cout = val[15];
      end
      rotate_left_plain_op:  res = {val[14:0], val[15]};
      rotate_right_carry_op: begin
        res  = {cin, val[15:1]};
        cout = val[0];
      end
      rotate_right_plain_op: res = {val[0], val[15:1]};
      left_shift_op: begin
        res  = {val[14:0], 1'b0};
        cout = val[15];
        ov   = val[15] ^ val[14];
      end
      // Counts of 16 and more empty the word
      left_shift_multi_op:
        res = (cnt >= `SSO_SHIFT_LIM) ? `SSO_RST_WORD : (val << cnt[3:0]);
      default: res = val;
    endcase
  end
endmodule
`default_nettype wire

/* design/sso_exec.sv */
// Execution unit for flow, rotate, shift, subtract, swap and table ops
// Operation
// - computed call jumps to Wn, 2 cycles
// - literal repeat runs next op lit+1 times
// - register repeat runs next op Wn+1 times
// - software reset triggers device reset, one cycle
// - interrupt return takes 3 or 2 cycles
// - literal return loads 10-bit literal, then returns
// - plain return takes 3 or 2 cycles
// - rotate left through carry, updates C N Z
// - plain rotate left keeps carry, updates N Z
// - rotate right through carry, updates C N Z
// - plain rotate right keeps carry, updates N Z
// - sign extend low byte, updates C N Z
// - set all ones, no flags changed
// - single left shift updates C N OV Z
// - multi-bit left shift updates only N Z
// - subtract updates all five arithmetic flags
// - borrow subtract also removes inverted carry
// - reverse subtract takes second minus base
// - nibble swap of low byte in place
// - byte swap of word in place
// - upper table read fills low byte, 2 cycles
`timescale 1ns/1ps
`default_nettype none
`include "sso_consts.svh"
module sso_exec
  import sso_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Instruction request
  input  wire logic        req_valid,
  input  wire sso_req_s    req,
  output logic             req_ready,
  // Return stack top and program memory data
  input  wire logic [15:0] ret_addr,
  input  wire logic [23:0] prog_data,
  // Results
  output sso_out_s         out,
  output sso_flags_s       flags,
  // Working register view
  input  wire logic [3:0]  view_idx,
  output logic [15:0]      view_data
);

  // --------------------------------------------------------------------
  // State and operand selection
  // --------------------------------------------------------------------
  sso_state_s  st;
  sso_state_s  next_st;
  sso_req_s    cur;
  logic        take;
  logic        phase_end;
  logic        go;
  logic        is_multi;
  logic        is_ret;
  logic        rev;
  logic        borrow;
  logic [15:0] base;
  logic [15:0] src;
  logic [15:0] second;
  logic [15:0] sub_a;
  logic [15:0] sub_b;
  logic [15:0] sub_res;
  sso_flags_s  sub_flg;
  logic [15:0] sh_val;
  logic [4:0]  sh_cnt;
  logic [15:0] sh_res;
  logic        sh_c;
  logic        sh_ov;
  logic [15:0] res;
  logic        wr;

  // New request only while idle; a repeat reissues the held request
  assign take      = !st.busy && req_valid;
  assign phase_end = st.busy && (st.wait_cnt == `SSO_WAIT_NONE);
  assign go        = take || (phase_end && (st.rpt != `SSO_RST_WORD));
  assign cur       = take ? req : st.held;
  assign req_ready = !st.busy;

  assign is_ret   = (cur.op == interrupt_return_op) || (cur.op == literal_return_op)
                 || (cur.op == plain_return_op);
  assign is_multi = is_ret || (cur.op == computed_call_op)
                 || (cur.op == relative_call_op) || (cur.op == upper_table_read_op);

  // File forms pair the file value with the default register
  assign base   = cur.use_file ? cur.fval : st.default_working_register[cur.wb];
  assign src    = cur.use_file ? cur.fval : st.default_working_register[cur.ws];
  assign second = cur.use_file ? st.default_working_register[`SSO_DEF_DEFAULT_WORKING_REGISTER]
                : (cur.use_lit ? cur.lit : st.default_working_register[cur.ws]);

  assign rev    = (cur.op == reverse_subtract_op) || (cur.op == reverse_subtract_borrow_op);
  assign borrow = (cur.op == subtract_borrow_op) || (cur.op == reverse_subtract_borrow_op);
  assign sub_a  = rev ? second : base;
  assign sub_b  = rev ? base : second;

  assign sh_val = (cur.op == left_shift_multi_op) ? base : src;
  assign sh_cnt = cur.use_lit ? cur.lit[4:0] : st.default_working_register[cur.ws][4:0];

  // --------------------------------------------------------------------
  // Datapath units
  // --------------------------------------------------------------------
  sso_sub u_sub (
    .a   (sub_a),
    .b   (sub_b),
    .cin (borrow ? st.flags.c : 1'b1),
    .res (sub_res),
    .flg (sub_flg)
  );

  sso_shift u_shift (
    .op   (cur.op),
    .val  (sh_val),
    .cin  (st.flags.c),
    .cnt  (sh_cnt),
    .res  (sh_res),
    .cout (sh_c),
    .ov   (sh_ov)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    next_st              = st;
    res                  = `SSO_RST_WORD;
    wr                   = 1'b0;
    next_st.out.done     = 1'b0;
    next_st.out.f_wr     = 1'b0;
    next_st.out.pc_load  = 1'b0;
    next_st.out.push     = 1'b0;
    next_st.out.sw_reset = 1'b0;
    next_st.out.prog_rd  = 1'b0;
    // Long returns spend one extra cycle here
    if (st.busy && (st.wait_cnt != `SSO_WAIT_NONE)) begin
      next_st.wait_cnt = `SSO_WAIT_NONE;
    end
    // Last cycle of a multi-cycle op, or end of a repeat pass
    if (phase_end) begin
      case (st.held.op)
        computed_call_op, relative_call_op: begin
          next_st.out.pc_load = 1'b1;
          next_st.out.push    = 1'b1;
          next_st.out.done    = 1'b1;
        end
        interrupt_return_op, literal_return_op, plain_return_op: begin
          next_st.out.pc_target = ret_addr;
          next_st.out.pc_load   = 1'b1;
          next_st.out.done      = 1'b1;
        end
        upper_table_read_op: begin
          next_st.default_working_register[st.held.wd][7:0] = prog_data[`SSO_UPPER_MSB:`SSO_UPPER_LSB];
          next_st.out.done              = 1'b1;
        end
        default: ;
      endcase
      if (st.rpt != `SSO_RST_WORD) begin
        next_st.rpt = st.rpt - 16'h0001;
      end else begin
        next_st.busy = 1'b0;
      end
    end
    if (go) begin
      next_st.held     = cur;
      next_st.busy     = is_multi || (next_st.rpt != `SSO_RST_WORD);
      next_st.wait_cnt = (is_ret && !cur.ret_short) ? `SSO_WAIT_LONG : `SSO_WAIT_NONE;
      // A repeated multi-cycle op must keep the done of the pass that just ended
      next_st.out.done = next_st.out.done || !is_multi;
      case (cur.op)
        computed_call_op: begin
          next_st.out.pc_target = st.default_working_register[cur.wb];
          next_st.out.push_addr = cur.pc + `SSO_PC_STEP;
        end
        relative_call_op: begin
          next_st.out.pc_target = cur.pc + cur.lit;
          next_st.out.push_addr = cur.pc + `SSO_PC_STEP;
        end
        repeat_lit_op: begin
          next_st.rpt  = {2'b00, cur.lit[`SSO_RPT_LIT_MSB:0]};
          next_st.busy = 1'b0;
        end
        repeat_reg_op: begin
          next_st.rpt  = st.default_working_register[cur.wb];
          next_st.busy = 1'b0;
        end
        soft_reset_op: begin
          next_st              = '0;
          next_st.out.sw_reset = 1'b1;
          next_st.out.done     = 1'b1;
        end
        literal_return_op: begin
          next_st.default_working_register[cur.wd] = {6'h00, cur.lit[`SSO_RET_LIT_MSB:0]};
        end
        rotate_left_carry_op, rotate_right_carry_op: begin
          res             = sh_res;
          wr              = 1'b1;
          next_st.flags.c = sh_c;
          next_st.flags.n = sh_res[15];
          next_st.flags.z = (sh_res == `SSO_RST_WORD);
        end
        rotate_left_plain_op, rotate_right_plain_op, left_shift_multi_op: begin
          res             = sh_res;
          wr              = 1'b1;
          next_st.flags.n = sh_res[15];
          next_st.flags.z = (sh_res == `SSO_RST_WORD);
        end
        // overflow from the top two bits
        left_shift_op: begin
          res              = sh_res;
          wr               = 1'b1;
          next_st.flags.c  = sh_c;
          next_st.flags.ov = sh_ov;
          next_st.flags.n  = sh_res[15];
          next_st.flags.z  = (sh_res == `SSO_RST_WORD);
        end
        sign_extend_op: begin
          res             = {{8{src[7]}}, src[7:0]};
          wr              = 1'b1;
          next_st.flags.c = !src[7];
          next_st.flags.n = src[7];
          next_st.flags.z = (src[7:0] == 8'h00);
        end
        set_all_ones_op: begin
          res = `SSO_ONES;
          wr  = 1'b1;
        end
        // all five flags from the subtractor
        subtract_op, subtract_borrow_op, reverse_subtract_op, reverse_subtract_borrow_op: begin
          res           = sub_res;
          wr            = 1'b1;
          next_st.flags = sub_flg;
        end
        nibble_swap_op: begin
          next_st.default_working_register[cur.wd][7:0] = {st.default_working_register[cur.wd][3:0], st.default_working_register[cur.wd][7:4]};
        end
        byte_swap_op: begin
          next_st.default_working_register[cur.wd] = {st.default_working_register[cur.wd][7:0], st.default_working_register[cur.wd][15:8]};
        end
        upper_table_read_op: begin
          next_st.out.prog_rd   = 1'b1;
          next_st.out.prog_addr = st.default_working_register[cur.ws];
        end
        default: ;
      endcase
      // Write-back: file forms go to the file or the default register
      if (wr) begin
        if (cur.use_file && cur.to_default_working_register) begin
          next_st.default_working_register[`SSO_DEF_DEFAULT_WORKING_REGISTER] = res;
        end else if (cur.use_file) begin
          next_st.out.f_wr   = 1'b1;
          next_st.out.f_data = res;
        end else begin
          next_st.default_working_register[cur.wd] = res;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out       = st.out;
  assign flags     = st.flags;
  assign view_data = st.default_working_register[view_idx];

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [15:0] wb_val;
  logic [15:0] wd_val;
  logic [15:0] wd_swapped;
  logic [15:0] lit14;
  logic [7:0]  prog_hi;
  logic        exp_c;
  logic        reg_sub;

  assign wb_val     = st.default_working_register[req.wb];
  assign wd_val     = st.default_working_register[req.wd];
  assign wd_swapped = {wd_val[7:0], wd_val[15:8]};
  assign lit14      = {2'b00, req.lit[`SSO_RPT_LIT_MSB:0]};
  assign prog_hi    = prog_data[`SSO_UPPER_MSB:`SSO_UPPER_LSB];
  assign exp_c      = st.default_working_register[req.wb] >= st.default_working_register[req.ws];
  assign reg_sub    = take && (req.op == subtract_op) && !req.use_file && !req.use_lit
                   && (st.rpt == `SSO_RST_WORD);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  call_two_cycles_a: assert property (
    take && (req.op == computed_call_op) && (st.rpt == `SSO_RST_WORD)
    |=> !out.done ##1 (out.done && out.pc_load && out.pc_target == $past(wb_val, 2)
        && flags == $past(flags, 2)))
    else $error("computed call timing or target wrong");

  repeat_lit_a: assert property (
    take && (req.op == repeat_lit_op) |=> (st.rpt == $past(lit14)) && req_ready && out.done)
    else $error("literal repeat count wrong");

  repeat_reg_a: assert property (
    take && (req.op == repeat_reg_op) |=> (st.rpt == $past(wb_val)) && flags == $past(flags))
    else $error("register repeat count wrong");

  soft_reset_a: assert property (
    take && (req.op == soft_reset_op) |=> out.sw_reset && out.done && !st.busy)
    else $error("software reset not raised");

  return_long_a: assert property (
    take && (req.op == plain_return_op) && !req.ret_short && (st.rpt == `SSO_RST_WORD)
    |=> !out.done [*2] ##1 (out.done && out.pc_load))
    else $error("return did not take three cycles");

  plain_rotate_a: assert property (
    take && (req.op == rotate_left_plain_op) |=> flags.c == $past(flags.c))
    else $error("plain rotate changed carry");

  byte_swap_a: assert property (
    take && (req.op == byte_swap_op) |=> st.default_working_register[$past(req.wd)] == $past(wd_swapped)
      && flags == $past(flags))
    else $error("byte swap result wrong");

  table_read_a: assert property (
    take && (req.op == upper_table_read_op) && (st.rpt == `SSO_RST_WORD)
    |=> out.prog_rd ##1 (out.done && st.default_working_register[$past(req.wd, 2)][7:0] == $past(prog_hi)))
    else $error("upper table read wrong");

  sub_carry_a: assert property (
    reg_sub |=> flags.c == $past(exp_c) && flags.z == (st.default_working_register[$past(req.wd)] == 16'h0000))
    else $error("subtract flags wrong");

  cover_repeat_c: cover property (take && req.op == repeat_lit_op ##[1:4] take ##[1:4] !st.busy);
  cover_short_ret_c: cover property (take && req.op == interrupt_return_op && req.ret_short);
  cover_borrow_c: cover property (take && req.op == reverse_subtract_borrow_op && !flags.c);

endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the shift, subtract and flow execution unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sso_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        rstn;
  logic        req_valid;
  sso_req_s    req;
  logic        req_ready;
  logic [15:0] ret_addr;
  logic [23:0] prog_data;
  sso_out_s    out;
  sso_flags_s  flags;
  logic [3:0]  view_idx;
  logic [15:0] view_data;
  int          failures;
  int          n_tests;
  int          cycles;
  sso_flags_s  mf;       // Expected flags, kept by the bench

  sso_exec DUT (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
                .req_ready(req_ready), .ret_addr(ret_addr), .prog_data(prog_data),
                .out(out), .flags(flags), .view_idx(view_idx), .view_data(view_data));

  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("failures %0d of n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles; a hang is cut short here
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("unexpected at %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chkf(input sso_flags_s got, input sso_flags_s exp, input string m);
    chk16({11'h000, got}, {11'h000, exp}, m);
  endtask

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // fm packs use_file, to_default_working_register, use_lit, ret_short; w packs wb, ws, wd
  function automatic sso_req_s mk(input sso_op_e op, input logic [3:0] fm,
                                  input logic [11:0] w, input logic [15:0] lit,
                                  input logic [15:0] fv);
    sso_req_s r;
    r = '0;
    r.op = op;
    {r.use_file, r.to_default_working_register, r.use_lit, r.ret_short, r.wb, r.ws, r.wd, r.lit, r.fval} =
      {fm, w, lit, fv};
    r.pc = 16'h0100;
    return r;
  endfunction

  // Reference difference a - b - !ci with {ov,n,z,dc,c} above the result
  function automatic logic [20:0] subm(input logic [15:0] a, input logic [15:0] b,
                                       input logic ci);
    logic [16:0] r;
    logic [4:0]  d;
    r = {1'b0, a} - {1'b0, b} - {16'h0000, ~ci};
    d = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~ci};
    return {(a[15] ^ b[15]) & (r[15] ^ a[15]), r[15], r[15:0] == 16'h0000, ~d[4], ~r[16],
            r[15:0]};
  endfunction

  // Holds the request until an edge sees ready high; that edge is the take
  task automatic send(input sso_req_s r);
    logic rdy;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= r;
    rdy = 1'b0;
    while (!rdy) begin
      @(negedge core_clk);
      rdy = (req_ready === 1'b1);
      @(posedge core_clk);
    end
    req_valid <= 1'b0;
  endtask

  // Sends, then checks the cycle of done and the flags seen with it
  task automatic exec(input sso_req_s r, input int lat);
    int n;
    send(r);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (out.done !== 1'b1 && n < 20);
    chk16(n[15:0], lat[15:0], "latency");
    chkf(flags, mf, "flags");
  endtask

  task automatic rdw(input logic [3:0] i, input logic [15:0] e, input string m);
    @(posedge core_clk);
    view_idx <= i;
    @(negedge core_clk);
    chk16(view_data, e, m);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sub;
    logic [20:0] e;
    logic [15:0] a;
    logic [15:0] b;
    sso_op_e     ops [4] = '{subtract_op, subtract_borrow_op, reverse_subtract_op,
                             reverse_subtract_borrow_op};
    logic [15:0] vals [3] = '{16'h1236, 16'h8000, 16'h0000};
    e = subm(16'h1234, 16'h0000, 1'b1);
    mf = e[20:16];
    exec(mk(subtract_op, 4'hC, 12'h000, 16'h0000, 16'h1234), 1);
    rdw(4'h0, 16'h1234, "default register load");
    // Register form: W1 = W1 - W0, a borrow is expected
    e = subm(16'h0000, 16'h1234, 1'b1);
    mf = e[20:16];
    exec(mk(subtract_op, 4'h0, 12'h101, 16'h0000, 16'h0000), 1);
    rdw(4'h1, e[15:0], "register difference");
    foreach (ops[i]) foreach (vals[j]) begin
      a = (i > 1) ? 16'h1234 : vals[j];
      b = (i > 1) ? vals[j] : 16'h1234;
      e = subm(a, b, (i % 2 == 1) ? mf.c : 1'b1);
      mf = e[20:16];
      exec(mk(ops[i], 4'h8, 12'h000, 16'h0000, vals[j]), 1);
      chk16(out.f_data, e[15:0], "difference");
    end
  endtask

  task automatic t_rot;
    logic [15:0] v;
    logic [15:0] e;
    sso_op_e     ops [4] = '{rotate_left_carry_op, rotate_left_plain_op,
                             rotate_right_carry_op, rotate_right_plain_op};
    v = 16'h8001;
    foreach (ops[k]) begin
      case (k)
        0: e = {v[14:0], mf.c};
        1: e = {v[14:0], v[15]};
        2: e = {mf.c, v[15:1]};
        default: e = {v[0], v[15:1]};
      endcase
      // Only the through-carry forms move the carry
      if (k == 0) mf.c = v[15];
      if (k == 2) mf.c = v[0];
      mf.n = e[15];
      mf.z = (e == 16'h0000);
      exec(mk(ops[k], 4'h8, 12'h000, 16'h0000, v), 1);
      chk16(out.f_data, e, "rotate");
    end
  endtask

  task automatic t_shift;
    mf = '{ov: 1'b1, n: 1'b1, z: 1'b0, dc: mf.dc, c: 1'b0};
    exec(mk(left_shift_op, 4'h8, 12'h000, 16'h0000, 16'h4001), 1);
    chk16(out.f_data, 16'h8002, "shift");
    mf = '{ov: 1'b1, n: 1'b0, z: 1'b1, dc: mf.dc, c: 1'b1};
    exec(mk(left_shift_op, 4'h8, 12'h000, 16'h0000, 16'h8000), 1);
    chk16({15'h0000, out.f_wr}, 16'h0001, "file write");
    // Multi-bit shift must leave carry and overflow as they were
    mf.z = 1'b0;
    exec(mk(left_shift_multi_op, 4'h2, 12'h002, 16'h0004, 16'h0000), 1);
    rdw(4'h2, 16'h2340, "multi shift");
    mf.z = 1'b1;
    exec(mk(left_shift_multi_op, 4'h2, 12'h008, 16'h0010, 16'h0000), 1);
    rdw(4'h8, 16'h0000, "shift by sixteen");
  endtask

  task automatic t_misc;
    mf = '{ov: mf.ov, n: 1'b0, z: 1'b0, dc: mf.dc, c: 1'b1};
    exec(mk(sign_extend_op, 4'h0, 12'h003, 16'h0000, 16'h0000), 1);
    rdw(4'h3, 16'h0034, "sign extend");
    exec(mk(set_all_ones_op, 4'h0, 12'h004, 16'h0000, 16'h0000), 1);
    rdw(4'h4, 16'hFFFF, "all ones");
    exec(mk(nibble_swap_op, 4'h0, 12'h000, 16'h0000, 16'h0000), 1);
    rdw(4'h0, 16'h1243, "nibble swap");
    exec(mk(byte_swap_op, 4'h0, 12'h000, 16'h0000, 16'h0000), 1);
    rdw(4'h0, 16'h4312, "byte swap");
  endtask

  task automatic t_flow;
    sso_op_e rets [3] = '{interrupt_return_op, literal_return_op, plain_return_op};
    exec(mk(computed_call_op, 4'h0, 12'h222, 16'h0000, 16'h0000), 2);
    chk16(out.pc_target, 16'h2340, "call target");
    chk16(out.push_addr, 16'h0102, "call push");
    chk16({14'h0000, out.pc_load, out.push}, 16'h0003, "call strobes");
    exec(mk(relative_call_op, 4'h0, 12'h000, 16'h0020, 16'h0000), 2);
    chk16(out.pc_target, 16'h0120, "relative target");
    @(posedge core_clk);
    ret_addr <= 16'h0456;
    foreach (rets[k]) for (int s = 0; s < 2; s++) begin
      exec(mk(rets[k], {3'b000, s[0]}, 12'h555, 16'h07A5, 16'h0000), 3 - s);
      chk16(out.pc_target, 16'h0456, "return target");
      chk16({15'h0000, out.pc_load}, 16'h0001, "return load");
    end
    rdw(4'h5, 16'h03A5, "return literal");
    @(posedge core_clk);
    prog_data <= 24'hABCDEF;
    exec(mk(upper_table_read_op, 4'h0, 12'h023, 16'h0000, 16'h0000), 2);
    chk16(out.prog_addr, 16'h2340, "table address");
    rdw(4'h3, 16'h00AB, "table read");
  endtask

  task automatic t_repeat;
    logic [20:0] e;
    int          n;
    e = subm(16'h0001, 16'h0000, 1'b1);
    mf = e[20:16];
    exec(mk(reverse_subtract_op, 4'h2, 12'h777, 16'h0001, 16'h0000), 1);
    for (int k = 0; k < 2; k++) begin
      exec(mk(k ? repeat_reg_op : repeat_lit_op, 4'h2, 12'h777, 16'h2, 16'h0), 1);
      send(mk(rotate_left_plain_op, 4'h0, 12'h555, 16'h0000, 16'h0000));
      n = 0;
      repeat (15) begin
        @(negedge core_clk);
        if (out.done === 1'b1) n++;
      end
      chk16(n[15:0], k ? 16'h0002 : 16'h0003, "passes");
      chkf(flags, mf, "repeat flags");
      rdw(4'h5, k ? 16'h74A0 : 16'h1D28, "repeated rotate");
    end
  endtask

  task automatic t_soft;
    mf = '0;
    exec(mk(soft_reset_op, 4'h0, 12'h000, 16'h0000, 16'h0000), 1);
    chk16({15'h0000, out.sw_reset}, 16'h0001, "reset strobe");
    rdw(4'h5, 16'h0000, "register cleared");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    ret_addr = 16'h0000;
    prog_data = 24'h000000;
    view_idx = 4'h0;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    mf = '0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk16({15'h0000, req_ready}, 16'h0001, "ready after reset");
    chkf(flags, mf, "flags after reset");
    t_sub();
    t_rot();
    t_shift();
    t_misc();
    t_flow();
    t_repeat();
    t_soft();
    end_sim();
  end
endmodule
`default_nettype wire
